// ===== inc/ssb_pkg.sv
// Constants shared by the supply status object bank: object indices,
// field positions and reset values.
// Assumes a service-object access port with a 16-bit index and 32-bit data.
`default_nettype none
package ssb_pkg;

    localparam logic [15:0] IDX_FAULT_SUMMARY  = 16'h200B;
    localparam logic [15:0] IDX_LIVE_STATUS    = 16'h200D;
    localparam logic [15:0] IDX_OUTPUT_CTRL    = 16'h200F;
    localparam logic [15:0] IDX_OUTPUT_RB      = 16'h2010;
    localparam logic [15:0] IDX_MEAS_CURRENT   = 16'h2101;
    localparam logic [15:0] IDX_MEAS_VOLTAGE   = 16'h2102;
    localparam logic [15:0] IDX_MEAS_POWER     = 16'h2103;

    // Fault summary word bit positions
    localparam int FS_VPROT = 0;
    localparam int FS_CTRIP = 1;
    localparam int FS_VTRIP = 2;
    localparam int FS_PTRIP = 3;
    localparam int FS_CPROT = 4;
    localparam int FS_OTP   = 5;
    localparam int FS_SENSE = 6;
    localparam int FS_MODE0 = 7;
    localparam int FS_SOFT  = 11;
    localparam int FS_HARD  = 12;
    localparam int FS_ILOCK = 13;
    localparam int FS_INPWR = 14;
    localparam int FS_LINE  = 15;

    // Live status word 0 bit positions
    localparam int S0_STANDBY  = 0;
    localparam int S0_LIVE     = 1;
    localparam int S0_SENSE    = 7;
    localparam int S0_COMM     = 15;
    localparam int S0_CUR_OVR  = 16;
    localparam int S0_VOLT_OVR = 17;
    localparam int S0_ILOCK    = 20;

    // Live status word 1 bit positions
    localparam int S1_PHASE    = 0;
    localparam int S1_FUSE     = 1;
    localparam int S1_FAN      = 2;
    localparam int S1_RATING   = 16;
    localparam int S1_FIRMWARE = 17;

    localparam logic        OUTPUT_EN_RESET = 1'b0;
    localparam logic [31:0] READ_DATA_RESET = 32'h0000_0000;
    localparam logic        SEL_WORD1       = 1'b1;

endpackage
`default_nettype wire

// ===== logic/ssb_word_latch.sv
// Small output register: holds one read word for the access port.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module ssb_word_latch (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        load,
    input  wire logic [31:0] din,
    output logic      [31:0] dout
);
    typedef struct packed {
        logic [31:0] word;
    } ssb_latch_state_t;

    ssb_latch_state_t st;
    ssb_latch_state_t next_st;

    always_comb begin
        next_st = st;
        if (load) begin
            next_st.word = din;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st.word <= ssb_pkg::READ_DATA_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.word;
endmodule
`default_nettype wire

// ===== logic/ssb_object_bank.sv
// Supply status object bank: live fault, mode and status objects,
// output enable control and averaged measurement objects.
// Assumes the fieldbus stack presents one indexed access per request strobe,
// all inputs synchronous to SYS_CLK.
//
// Overview of operation
// (RULE1) Fault summary object is live, read-only, unlatched
// (RULE2) Bits 0,4,5,6 are hard faults
// (RULE3) Bits 1,2,3 are soft trip faults
// (RULE4) Bits 7-10 flag current, voltage, resistance, power mode
// (RULE5) Bit 11 is OR of soft faults
// (RULE6) Bit 12 is OR of hard faults
// (RULE7) Bits 13-15: interlock, input loss, line fault
// (RULE8) Live status words read-only, reads change nothing
// (RULE9) Summary bit meanings fixed; status layout may move
// (RULE10) Status0 bit0 standby, bit1 output active
// (RULE11) Status0 bit7 sense voltage out of bounds
// (RULE12) Status0 bits16,17 terminal current, voltage over rating
// (RULE13) Status0 bit15 comm corrupt, bit20 interlock
// (RULE14) Status1 bits0-2 phase, fuse, fan stall
// (RULE15) Status1 bits16,17 rating, firmware mismatch
// (RULE16) Write 1 enables output, readback active only
// (RULE17) Current object returns averaged current float
// (RULE18) Voltage object returns sense voltage when engaged
// (RULE19) Power object returns averaged power float
// (RULE20) Available and upper summary bits read zero
`timescale 1ns/100ps
`default_nettype none
module ssb_object_bank (
    input  wire logic        SYS_CLK,
    input  wire logic        RSTN,
    // Service object access port
    input  wire logic        OBJ_REQ,
    input  wire logic        OBJ_WRITE,
    input  wire logic [15:0] OBJ_INDEX,
    input  wire logic        OBJ_SUBSEL,
    input  wire logic [31:0] OBJ_WDATA,
    output logic             OBJ_ACK,
    output logic             OBJ_ERR,
    output logic      [31:0] OBJ_RDATA,
    // Live conditions from the power stage
    input  wire logic        OVERVOLTAGE_PROTECTION_FLAG,
    input  wire logic        OVERCURRENT_TRIP_FLAG,
    input  wire logic        OVERVOLTAGE_TRIP_FLAG,
    input  wire logic        OVERPOWER_TRIP_FLAG,
    input  wire logic        OVERCURRENT_PROTECTION_FLAG,
    input  wire logic        OVERTEMP_PROTECTION_FLAG,
    input  wire logic        SENSE_LOSS_FLAG,
    input  wire logic [3:0]  REGULATION_MODE,
    input  wire logic        INTERLOCK_OPEN_FLAG,
    input  wire logic        INPUT_POWER_LOSS_FLAG,
    input  wire logic        INPUT_LINE_FAULT_FLAG,
    input  wire logic        POWER_STAGE_ACTIVE,
    input  wire logic        SENSE_OUT_OF_BOUNDS,
    input  wire logic        COMM_CORRUPT_FLAG,
    input  wire logic        TERMINAL_CURRENT_OVER_RATING,
    input  wire logic        TERMINAL_VOLTAGE_OVER_RATING,
    input  wire logic        MISSING_PHASE_FLAG,
    input  wire logic        INPUT_FUSE_OPEN_FLAG,
    input  wire logic        FAN_STALL_FLAG,
    input  wire logic        BAD_RATING_FLAG,
    input  wire logic        FIRMWARE_MISMATCH_FLAG,
    // Averaged measurements, IEEE single precision
    input  wire logic [31:0] AVG_CURRENT,
    input  wire logic [31:0] AVG_TERMINAL_VOLTAGE,
    input  wire logic [31:0] AVG_SENSE_VOLTAGE,
    input  wire logic        REMOTE_SENSE_ENGAGED,
    input  wire logic [31:0] AVG_POWER,
    // Output enable request toward the power stage
    output logic             OUTPUT_ENABLE
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic out_en;
        logic ack;
        logic err;
    } ssb_state_t;

    ssb_state_t  st;
    ssb_state_t  next_st;
    logic [15:0] fault_summary;
    logic [31:0] status0;
    logic [31:0] status1;
    logic [31:0] rd_word;
    logic        idx_known;
    logic        rd_load;
    logic        soft_any;
    logic        hard_any;
    logic        active;

    // ************************************************************
    // Live objects
    // ************************************************************
    // Only the output enable behind status0 bits 0 and 1 is stored; every other flag
    // is combinational from its source, so a read can never latch or clear it.
    assign soft_any = OVERCURRENT_TRIP_FLAG | OVERVOLTAGE_TRIP_FLAG
                    | OVERPOWER_TRIP_FLAG;
    assign hard_any = OVERVOLTAGE_PROTECTION_FLAG | OVERCURRENT_PROTECTION_FLAG
                    | OVERTEMP_PROTECTION_FLAG | SENSE_LOSS_FLAG;
    // Active only when enabled and the stage actually processes power
    assign active   = st.out_en & POWER_STAGE_ACTIVE;                     // RULE16

    always_comb begin
        fault_summary                     = 16'h0000;                      // RULE20
        fault_summary[ssb_pkg::FS_VPROT]  = OVERVOLTAGE_PROTECTION_FLAG;   // RULE2
        fault_summary[ssb_pkg::FS_CPROT]  = OVERCURRENT_PROTECTION_FLAG;   // RULE2
        fault_summary[ssb_pkg::FS_OTP]    = OVERTEMP_PROTECTION_FLAG;      // RULE2
        fault_summary[ssb_pkg::FS_SENSE]  = SENSE_LOSS_FLAG;               // RULE2
        fault_summary[ssb_pkg::FS_CTRIP]  = OVERCURRENT_TRIP_FLAG;         // RULE3
        fault_summary[ssb_pkg::FS_VTRIP]  = OVERVOLTAGE_TRIP_FLAG;         // RULE3
        fault_summary[ssb_pkg::FS_PTRIP]  = OVERPOWER_TRIP_FLAG;           // RULE3
        fault_summary[ssb_pkg::FS_MODE0 +: 4] = REGULATION_MODE;           // RULE4
        fault_summary[ssb_pkg::FS_SOFT]   = soft_any;                      // RULE5
        fault_summary[ssb_pkg::FS_HARD]   = hard_any;                      // RULE6
        fault_summary[ssb_pkg::FS_ILOCK]  = INTERLOCK_OPEN_FLAG;           // RULE7
        fault_summary[ssb_pkg::FS_INPWR]  = INPUT_POWER_LOSS_FLAG;         // RULE7
        fault_summary[ssb_pkg::FS_LINE]   = INPUT_LINE_FAULT_FLAG;         // RULE7
    end

    // Only documented status bits are wired; the rest stay zero so the
    // layout can grow later without touching the summary word.
    always_comb begin // RULE9
        status0                          = 32'h0000_0000;                  // RULE20
        status0[ssb_pkg::S0_STANDBY]     = ~active;                        // RULE10
        status0[ssb_pkg::S0_LIVE]        = active;                         // RULE10
        status0[ssb_pkg::S0_SENSE]       = SENSE_OUT_OF_BOUNDS;            // RULE11
        status0[ssb_pkg::S0_CUR_OVR]     = TERMINAL_CURRENT_OVER_RATING;   // RULE12
        status0[ssb_pkg::S0_VOLT_OVR]    = TERMINAL_VOLTAGE_OVER_RATING;   // RULE12
        status0[ssb_pkg::S0_COMM]        = COMM_CORRUPT_FLAG;              // RULE13
        status0[ssb_pkg::S0_ILOCK]       = INTERLOCK_OPEN_FLAG;            // RULE13
        status1                          = 32'h0000_0000;                  // RULE20
        status1[ssb_pkg::S1_PHASE]       = MISSING_PHASE_FLAG;             // RULE14
        status1[ssb_pkg::S1_FUSE]        = INPUT_FUSE_OPEN_FLAG;           // RULE14
        status1[ssb_pkg::S1_FAN]         = FAN_STALL_FLAG;                 // RULE14
        status1[ssb_pkg::S1_RATING]      = BAD_RATING_FLAG;                // RULE15
        status1[ssb_pkg::S1_FIRMWARE]    = FIRMWARE_MISMATCH_FLAG;         // RULE15
    end

    // ************************************************************
    // Object decode
    // ************************************************************
    always_comb begin
        rd_word   = 32'h0000_0000;
        idx_known = 1'b1;
        unique case (OBJ_INDEX)
            ssb_pkg::IDX_FAULT_SUMMARY: rd_word = {16'h0000, fault_summary}; // RULE1
            ssb_pkg::IDX_LIVE_STATUS: begin
                // Sub-select picks status word 1 over word 0
                rd_word = (OBJ_SUBSEL == ssb_pkg::SEL_WORD1) ? status1 : status0; // RULE8
            end
            ssb_pkg::IDX_OUTPUT_CTRL:  rd_word = {31'h0, st.out_en};
            ssb_pkg::IDX_OUTPUT_RB:    rd_word = {31'h0, active};           // RULE16
            ssb_pkg::IDX_MEAS_CURRENT: rd_word = AVG_CURRENT;              // RULE17
            ssb_pkg::IDX_MEAS_VOLTAGE: begin
                rd_word = REMOTE_SENSE_ENGAGED ? AVG_SENSE_VOLTAGE
                                               : AVG_TERMINAL_VOLTAGE;     // RULE18
            end
            ssb_pkg::IDX_MEAS_POWER:   rd_word = AVG_POWER;                // RULE19
            default:                   idx_known = 1'b0;
        endcase
    end

    // ************************************************************
    // Access sequencing
    // ************************************************************
    // Writes to read-only or unknown objects are refused with an error and
    // leave all state untouched.
    always_comb begin
        next_st     = st;
        next_st.ack = OBJ_REQ;
        next_st.err = 1'b0;
        if (OBJ_REQ) begin
            if (!idx_known) begin
                next_st.err = 1'b1;
            end else if (OBJ_WRITE) begin
                if (OBJ_INDEX == ssb_pkg::IDX_OUTPUT_CTRL) begin
                    next_st.out_en = OBJ_WDATA[0];                          // RULE16
                end else begin
                    next_st.err = 1'b1;                                     // RULE1
                end
            end
        end
    end

    assign rd_load = OBJ_REQ & ~OBJ_WRITE & idx_known;

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            st.out_en <= ssb_pkg::OUTPUT_EN_RESET;
            st.ack    <= 1'b0;
            st.err    <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    ssb_word_latch u_rdata (
        .clk  (SYS_CLK),
        .rstn (RSTN),
        .load (rd_load),
        .din  (rd_word),
        .dout (OBJ_RDATA)
    );

    assign OBJ_ACK       = st.ack;
    assign OBJ_ERR       = st.err;
    assign OUTPUT_ENABLE = st.out_en;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_fs_read;
        @(posedge SYS_CLK) disable iff (!RSTN)
        (OBJ_REQ && !OBJ_WRITE && OBJ_INDEX == ssb_pkg::IDX_FAULT_SUMMARY)
            |=> (OBJ_RDATA == $past(rd_word) && OBJ_RDATA[31:16] == 16'h0000);
    endproperty
    a_fs_read: assert property (p_fs_read) else $error("summary read wrong"); // RULE1

    property p_hard_sum;
        @(posedge SYS_CLK) disable iff (!RSTN)
        fault_summary[ssb_pkg::FS_HARD] == (fault_summary[0] | fault_summary[4]
            | fault_summary[5] | fault_summary[6]);
    endproperty
    a_hard_sum: assert property (p_hard_sum) else $error("hard summary wrong"); // RULE6

    property p_soft_sum;
        @(posedge SYS_CLK) disable iff (!RSTN)
        fault_summary[ssb_pkg::FS_SOFT] == (|fault_summary[3:1]);
    endproperty
    a_soft_sum: assert property (p_soft_sum) else $error("soft summary wrong"); // RULE5

    property p_out_write;
        @(posedge SYS_CLK) disable iff (!RSTN)
        (OBJ_REQ && OBJ_WRITE && OBJ_INDEX == ssb_pkg::IDX_OUTPUT_CTRL)
            |=> (OUTPUT_ENABLE == $past(OBJ_WDATA[0]) && OBJ_ACK && !OBJ_ERR);
    endproperty
    a_out_write: assert property (p_out_write) else $error("enable write lost"); // RULE16

    property p_standby;
        @(posedge SYS_CLK) disable iff (!RSTN)
        status0[ssb_pkg::S0_STANDBY] != status0[ssb_pkg::S0_LIVE];
    endproperty
    a_standby: assert property (p_standby) else $error("standby and live agree"); // RULE10

    property p_ro_write;
        @(posedge SYS_CLK) disable iff (!RSTN)
        (OBJ_REQ && OBJ_WRITE && OBJ_INDEX != ssb_pkg::IDX_OUTPUT_CTRL)
            |=> (OBJ_ERR && $stable(OUTPUT_ENABLE));
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only object written"); // RULE8

    property p_volt_sel;
        @(posedge SYS_CLK) disable iff (!RSTN)
        (OBJ_REQ && !OBJ_WRITE && OBJ_INDEX == ssb_pkg::IDX_MEAS_VOLTAGE
            && REMOTE_SENSE_ENGAGED) |=> OBJ_RDATA == $past(AVG_SENSE_VOLTAGE);
    endproperty
    a_volt_sel: assert property (p_volt_sel) else $error("sense voltage not chosen"); // RULE18

    property p_status1_zero;
        @(posedge SYS_CLK) disable iff (!RSTN)
        (OBJ_REQ && !OBJ_WRITE && OBJ_INDEX == ssb_pkg::IDX_LIVE_STATUS && OBJ_SUBSEL)
            |=> (OBJ_RDATA[15:3] == 13'h0 && OBJ_RDATA[31:18] == 14'h0);
    endproperty
    a_status1_zero: assert property (p_status1_zero) else $error("unused bits set"); // RULE20

    property p_rb_fault;
        @(posedge SYS_CLK) disable iff (!RSTN)
        (OBJ_REQ && !OBJ_WRITE && OBJ_INDEX == ssb_pkg::IDX_OUTPUT_RB && !POWER_STAGE_ACTIVE)
            |=> OBJ_RDATA == 32'h0000_0000;
    endproperty
    a_rb_fault: assert property (p_rb_fault) else $error("readback shows active"); // RULE16

    property p_ack_pulse;
        @(posedge SYS_CLK) disable iff (!RSTN)
        OBJ_REQ |=> OBJ_ACK;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("no acknowledge"); // RULE1

    property p_ack_idle;
        @(posedge SYS_CLK) disable iff (!RSTN)
        !OBJ_REQ |=> (!OBJ_ACK && !OBJ_ERR);
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("stray acknowledge"); // RULE1

    property p_rdata_hold;
        @(posedge SYS_CLK) disable iff (!RSTN)
        !(OBJ_REQ && !OBJ_WRITE) |=> $stable(OBJ_RDATA);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved"); // RULE8

    property p_status0_zero;
        @(posedge SYS_CLK) disable iff (!RSTN)
        (OBJ_REQ && !OBJ_WRITE && OBJ_INDEX == ssb_pkg::IDX_LIVE_STATUS && !OBJ_SUBSEL)
            |=> (OBJ_RDATA[6:2] == 5'h00 && OBJ_RDATA[14:8] == 7'h00
            && OBJ_RDATA[19:18] == 2'h0 && OBJ_RDATA[31:21] == 11'h000);
    endproperty
    a_status0_zero: assert property (p_status0_zero) else $error("status0 spare set"); // RULE20

    property p_mode_map;
        @(posedge SYS_CLK) disable iff (!RSTN)
        fault_summary[ssb_pkg::FS_MODE0 +: 4] == REGULATION_MODE;
    endproperty
    a_mode_map: assert property (p_mode_map) else $error("mode bits wrong"); // RULE4

    property p_subset;
        @(posedge SYS_CLK) disable iff (!RSTN)
        fault_summary[ssb_pkg::FS_ILOCK] == status0[ssb_pkg::S0_ILOCK];
    endproperty
    a_subset: assert property (p_subset) else $error("interlock views differ"); // RULE9

    property p_rb_on;
        @(posedge SYS_CLK) disable iff (!RSTN)
        (OBJ_REQ && !OBJ_WRITE && OBJ_INDEX == ssb_pkg::IDX_OUTPUT_RB && OUTPUT_ENABLE
            && POWER_STAGE_ACTIVE) |=> OBJ_RDATA == 32'h0000_0001;
    endproperty
    a_rb_on: assert property (p_rb_on) else $error("readback shows standby"); // RULE16

    property p_enable_hold;
        @(posedge SYS_CLK) disable iff (!RSTN)
        !(OBJ_REQ && OBJ_WRITE) |=> $stable(OUTPUT_ENABLE);
    endproperty
    a_enable_hold: assert property (p_enable_hold) else $error("enable moved"); // RULE16

    property p_curr_read;
        @(posedge SYS_CLK) disable iff (!RSTN)
        (OBJ_REQ && !OBJ_WRITE && OBJ_INDEX == ssb_pkg::IDX_MEAS_CURRENT)
            |=> OBJ_RDATA == $past(AVG_CURRENT);
    endproperty
    a_curr_read: assert property (p_curr_read) else $error("current word wrong"); // RULE17

    property p_pwr_read;
        @(posedge SYS_CLK) disable iff (!RSTN)
        (OBJ_REQ && !OBJ_WRITE && OBJ_INDEX == ssb_pkg::IDX_MEAS_POWER)
            |=> OBJ_RDATA == $past(AVG_POWER);
    endproperty
    a_pwr_read: assert property (p_pwr_read) else $error("power word wrong"); // RULE19

    property p_volt_term;
        @(posedge SYS_CLK) disable iff (!RSTN)
        (OBJ_REQ && !OBJ_WRITE && OBJ_INDEX == ssb_pkg::IDX_MEAS_VOLTAGE
            && !REMOTE_SENSE_ENGAGED) |=> OBJ_RDATA == $past(AVG_TERMINAL_VOLTAGE);
    endproperty
    a_volt_term: assert property (p_volt_term) else $error("terminal voltage wrong"); // RULE18

endmodule
`default_nettype wire

// ===== tb/ssb_master_model.sv
// Fieldbus master model: issues one indexed object access per call.
// Assumes the bank answers with a one-cycle acknowledge after the request.
`timescale 1ns/100ps
`default_nettype none
module ssb_master_model (
    input  wire logic        clk,
    input  wire logic        ack,
    input  wire logic        err,
    input  wire logic [31:0] rdata,
    output logic             req,
    output logic             write,
    output logic      [15:0] index,
    output logic             subsel,
    output logic      [31:0] wdata
);
    initial begin
        req    = 1'b0;
        write  = 1'b0;
        index  = 16'h0000;
        subsel = 1'b0;
        wdata  = 32'h0000_0000;
    end
    // ************************************************************
    // Access
    // ************************************************************
    // Released qualifiers are inverted so a stale value never looks valid
    task automatic xfer(input logic w, input logic [15:0] idx, input logic sub,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic er, output logic ok);
        ok = 1'b0;
        rd = 32'h0000_0000;
        er = 1'b0;
        @(posedge clk);
        req    <= 1'b1;
        write  <= w;
        index  <= idx;
        subsel <= sub;
        wdata  <= wd;
        @(posedge clk);
        req    <= 1'b0;
        write  <= ~w;
        index  <= ~idx;
        subsel <= ~sub;
        wdata  <= ~wd;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            if (ack === 1'b1) begin
                rd = rdata;
                er = err;
                ok = 1'b1;
            end
        end
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the supply status object bank.
// Assumes the master model in ssb_master_model and the bank's own assertions.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        sys_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic [23:0] cond    = 24'h00_0000;
    logic        sense   = 1'b0;
    logic [31:0] avg_i   = 32'h3FC0_0000;
    logic [31:0] avg_vt  = 32'h4248_0000;
    logic [31:0] avg_vs  = 32'h4247_0000;
    logic [31:0] avg_p   = 32'h4496_0000;
    logic        req, wr, sub, ack, err, out_en;
    logic [15:0] idx;
    logic [31:0] wdat, rdat, d;
    logic        e;
    int          n_errors = 0;
    int          n_checks = 0;

    always #50 sys_clk = ~sys_clk;

    ssb_master_model i_master (.clk(sys_clk), .ack(ack), .err(err), .rdata(rdat),
        .req(req), .write(wr), .index(idx), .subsel(sub), .wdata(wdat));

    ssb_object_bank i_dut (.SYS_CLK(sys_clk), .RSTN(rstn), .OBJ_REQ(req), .OBJ_WRITE(wr),
        .OBJ_INDEX(idx), .OBJ_SUBSEL(sub), .OBJ_WDATA(wdat), .OBJ_ACK(ack), .OBJ_ERR(err),
        .OBJ_RDATA(rdat), .OVERVOLTAGE_PROTECTION_FLAG(cond[0]),
        .OVERCURRENT_TRIP_FLAG(cond[1]), .OVERVOLTAGE_TRIP_FLAG(cond[2]),
        .OVERPOWER_TRIP_FLAG(cond[3]), .OVERCURRENT_PROTECTION_FLAG(cond[4]),
        .OVERTEMP_PROTECTION_FLAG(cond[5]), .SENSE_LOSS_FLAG(cond[6]),
        .REGULATION_MODE(cond[10:7]), .INTERLOCK_OPEN_FLAG(cond[11]),
        .INPUT_POWER_LOSS_FLAG(cond[12]), .INPUT_LINE_FAULT_FLAG(cond[13]),
        .POWER_STAGE_ACTIVE(cond[14]), .SENSE_OUT_OF_BOUNDS(cond[15]),
        .COMM_CORRUPT_FLAG(cond[16]), .TERMINAL_CURRENT_OVER_RATING(cond[17]),
        .TERMINAL_VOLTAGE_OVER_RATING(cond[18]), .MISSING_PHASE_FLAG(cond[19]),
        .INPUT_FUSE_OPEN_FLAG(cond[20]), .FAN_STALL_FLAG(cond[21]),
        .BAD_RATING_FLAG(cond[22]), .FIRMWARE_MISMATCH_FLAG(cond[23]),
        .AVG_CURRENT(avg_i), .AVG_TERMINAL_VOLTAGE(avg_vt), .AVG_SENSE_VOLTAGE(avg_vs),
        .REMOTE_SENSE_ENGAGED(sense), .AVG_POWER(avg_p), .OUTPUT_ENABLE(out_en));

    // ************************************************************
    // Expected words
    // ************************************************************
    function automatic logic [31:0] exp_fs(input logic [23:0] c);
        exp_fs = {16'h0000, c[13:11], c[0] | c[4] | c[5] | c[6], |c[3:1], c[10:0]};
    endfunction

    function automatic logic [31:0] exp_s0(input logic [23:0] c, input logic en);
        logic act;
        act = en & c[14];
        exp_s0 = {11'h000, c[11], 2'b00, c[18:17], c[16], 7'h00, c[15], 5'h00, act, ~act};
    endfunction

    function automatic logic [31:0] exp_s1(input logic [23:0] c);
        exp_s1 = {14'h0000, c[23:22], 13'h0000, c[21:19]};
    endfunction

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Hung access counts as a mismatch and ends the run
    task automatic acc(input logic w, input logic [15:0] x, input logic s, input logic [31:0] wd);
        logic ok;
        i_master.xfer(w, x, s, wd, d, e, ok);
        if (!ok) begin
            n_errors++;
            $display("wrong value acknowledge expected 1 seen 0");
            close_out();
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset;
        repeat (10) @(posedge sys_clk);
        check("reset ack", 32'h0, {31'h0, ack});
        check("reset enable", 32'h0, {31'h0, out_en});
        check("reset data", 32'h0, rdat);
        rstn <= 1'b1;
        $display("test reset done");
    endtask

    task automatic t_flags;
        for (int i = 0; i <= 24; i++) begin
            @(posedge sys_clk);
            cond <= (i == 24) ? 24'hFF_FFFF : 24'h00_0001 << i;
            acc(1'b0, 16'h200B, 1'b0, 32'h0);
            check("summary", exp_fs(cond), d);
            acc(1'b0, 16'h200B, 1'b0, 32'h0);
            check("summary again", exp_fs(cond), d);
            acc(1'b0, 16'h200D, 1'b0, 32'h0);
            check("status0", exp_s0(cond, 1'b0), d);
            acc(1'b0, 16'h200D, 1'b1, 32'h0);
            check("status1", exp_s1(cond), d);
        end
        $display("test flags done");
    endtask

    task automatic t_output;
        @(posedge sys_clk);
        cond <= 24'h00_4000;
        acc(1'b1, 16'h200F, 1'b0, 32'h0000_0001);
        check("enable", 32'h1, {31'h0, out_en});
        check("write error", 32'h0, {31'h0, e});
        acc(1'b0, 16'h200F, 1'b0, 32'h0);
        check("enable read", 32'h1, d);
        acc(1'b0, 16'h2010, 1'b0, 32'h0);
        check("readback active", 32'h1, d);
        acc(1'b0, 16'h200D, 1'b0, 32'h0);
        check("status0 live", exp_s0(cond, 1'b1), d);
        @(posedge sys_clk);
        cond <= 24'h00_0000;
        acc(1'b0, 16'h2010, 1'b0, 32'h0);
        check("readback faulted", 32'h0, d);
        acc(1'b0, 16'h200D, 1'b0, 32'h0);
        check("status0 faulted", exp_s0(cond, 1'b1), d);
        acc(1'b1, 16'h200F, 1'b0, 32'h0);
        check("standby", 32'h0, {31'h0, out_en});
        $display("test output done");
    endtask

    task automatic t_meas;
        acc(1'b0, 16'h2101, 1'b0, 32'h0);
        check("current", avg_i, d);
        check("read error", 32'h0, {31'h0, e});
        acc(1'b0, 16'h2102, 1'b0, 32'h0);
        check("terminal voltage", avg_vt, d);
        @(posedge sys_clk);
        sense <= 1'b1;
        acc(1'b0, 16'h2102, 1'b0, 32'h0);
        check("sense voltage", avg_vs, d);
        acc(1'b0, 16'h2103, 1'b0, 32'h0);
        check("power", avg_p, d);
        $display("test measure done");
    endtask

    // Reset in mid-run must drop the stored enable and the held read word
    task automatic t_midreset;
        acc(1'b1, 16'h200F, 1'b0, 32'h0000_0001);
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check("midrun enable", 32'h0, {31'h0, out_en});
        check("midrun data", 32'h0, rdat);
        rstn <= 1'b1;
        acc(1'b0, 16'h200F, 1'b0, 32'h0);
        check("enable after reset", 32'h0, d);
        $display("test midrun reset done");
    endtask

    // Writes to read-only objects and unknown indices must change nothing
    task automatic t_refuse;
        logic [15:0] ro [7] = '{16'h200B, 16'h200D, 16'h2010, 16'h2101, 16'h2102,
                                16'h2103, 16'h2104};
        acc(1'b0, 16'h2101, 1'b0, 32'h0);
        foreach (ro[k]) begin
            acc(1'b1, ro[k], 1'b0, 32'hFFFF_FFFF);
            check("refused write", 32'h1, {31'h0, e});
            check("enable kept", 32'h0, {31'h0, out_en});
            check("held data", avg_i, rdat);
        end
        acc(1'b0, 16'h200C, 1'b0, 32'h0);
        check("unknown read", 32'h1, {31'h0, e});
        check("held data", avg_i, rdat);
        $display("test refuse done");
    endtask

    initial begin
        t_reset();
        t_flags();
        t_output();
        t_meas();
        t_midreset();
        t_refuse();
        close_out();
    end
endmodule
`default_nettype wire
